// *** hdl/pwj_pkg.sv ***
// Constants and types shared by the pause, watchdog and jabber control block
package pwj_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SELECT = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int BIT_COND_MODE = 32'hf;
  localparam int BIT_SEND_ZERO = 32'he;
  localparam int BIT_SEND_MAX = 32'hd;
  localparam int BIT_FLOW_EN = 32'ha;
  localparam int BIT_VLAN = 32'h6;
  localparam int BIT_REL_SEL = 32'h5;
  localparam int BIT_WD_DIS = 32'h4;
  localparam int BIT_JAB_DIS = 32'h0;
  localparam logic RESET_CTRL_BIT = 1'h0;

  // ----------------------------------------------------------------
  // Sample-frame selector field and codes
  // ----------------------------------------------------------------
  localparam int SEL_LSB = 32'h3;
  localparam int SEL_MSB = 32'h8;
  localparam logic [5:0] SEL_TX_FIFO = 6'h32;
  localparam logic [5:0] SEL_RX_FIFO = 6'h35;
  localparam logic [5:0] SEL_DIAG_RESET = 6'h38;
  localparam logic [5:0] RESET_SEL = 6'h00;
  localparam int DIAG_DEPTH = 32'h10;
  localparam int DIAG_PTR_W = 32'h4;

  // ----------------------------------------------------------------
  // Pause frame values
  // ----------------------------------------------------------------
  localparam logic [15:0] PAUSE_TIME_ZERO = 16'h0000;
  localparam logic [15:0] PAUSE_TIME_MAX = 16'hffff;
  localparam logic [1:0] KIND_COND = 2'h0;
  localparam logic [1:0] KIND_ZERO = 2'h1;
  localparam logic [1:0] KIND_MAX = 2'h2;

  typedef enum logic [1:0] {
    PWJ_P_IDLE = 2'b01,
    PWJ_P_BUSY = 2'b10
  } pwj_pause_e;

  // ----------------------------------------------------------------
  // Frame lengths and timing
  // ----------------------------------------------------------------
  localparam logic [10:0] LEN_STD = 11'h5ee;
  localparam logic [10:0] LEN_VLAN = 11'h5f2;
  localparam int CLK_PERIOD_NS = 32'h64;
  localparam int BIT_TIME_NS = 32'h64;
  localparam int REL_LONG_BITS = 32'h28;
  localparam int REL_SHORT_BITS = 32'h10;
  localparam int REL_LONG_CYC =
    (REL_LONG_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REL_SHORT_CYC =
    (REL_SHORT_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_EXPIRE_DEFAULT = 32'h5000;
  localparam int JAB_EXPIRE_DEFAULT = 32'h5000;

  // ----------------------------------------------------------------
  // Interrupt bits
  // ----------------------------------------------------------------
  localparam int INT_RX_PAUSE = 32'h0;
  localparam int INT_TX_PAUSE = 32'h1;
  localparam int INT_WATCHDOG = 32'h2;
  localparam int INT_JABBER = 32'h3;
  localparam logic [3:0] RESET_INT = 4'h0;

endpackage : pwj_pkg

// *** hdl/pwj_diag_fifo.sv ***
// Diagnostic FIFO image with a word pointer for the sample-frame data port
`timescale 1ns/1ns
`default_nettype none
module pwj_diag_fifo (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ptr_clear,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data,
  output logic [pwj_pkg::DIAG_PTR_W-1:0] ptr
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] mem [0:pwj_pkg::DIAG_DEPTH-1];

  assign rd_data = mem[ptr];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[ptr] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Pointer, one word per access
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst || ptr_clear) begin
      ptr <= '0;
    end else if (wr_en || rd_en) begin
      ptr <= ptr + 1'b1;
    end
  end

endmodule : pwj_diag_fifo
`default_nettype wire

// *** hdl/pwj_ctrl.sv ***
// Pause, receive watchdog, jabber and diagnostic selector control block
//
// Behaviour
// - Mode one: request pause frame when either trigger condition is set.
// - Mode zero: request pause frame only while both trigger conditions set.
// - Zero-pause command sends pause time 0000h, clears itself when sent.
// - Max-pause command sends pause time ffffh, clears itself when sent.
// - Received pause frames are acted on only while flow control enabled.
// - Sticky bit latches each decoded pause frame; cleared by reading.
// - Read-only bit shows the live unlatched pause decode result.
// - VLAN enable raises accepted frame length to tagged length.
// - Release interval 40 bit times when select is one, 16 otherwise.
// - Watchdog expiry disables receive, re-enabled after release interval.
// - Watchdog timer runs while its disable bit is zero, stopped otherwise.
// - Jabber protection applies only while the jabber disable bit is zero.
// - Selector 32h routes the data port to the transmit FIFO.
// - Selector 35h routes the data port to the receive FIFO.
// - Selector 38h write resets diagnostic pointers, reads return nothing.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module pwj_ctrl #(
  parameter int WD_EXPIRE_CYCLES = pwj_pkg::WD_EXPIRE_DEFAULT,
  parameter int JAB_EXPIRE_CYCLES = pwj_pkg::JAB_EXPIRE_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic pause_cond_a,
  input wire logic pause_cond_b,
  output logic pause_tx_req,
  output logic [15:0] pause_tx_time,
  input wire logic pause_tx_done,
  input wire logic rx_pause_valid,
  input wire logic [15:0] rx_pause_time,
  output logic rx_pause_apply,
  output logic [15:0] rx_pause_quanta,
  output logic [10:0] max_frame_len,
  input wire logic rx_active,
  output logic rx_channel_enable,
  input wire logic tx_active,
  output logic tx_jabber_cut,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic pause_condition_mode;
  logic send_zero_pause;
  logic send_max_pause;
  logic flow_control_decode_enable;
  logic pause_received_latched;
  logic pause_decode_live;
  logic vlan_len_enable;
  logic watchdog_release_select;
  logic watchdog_timer_disable;
  logic tx_jabber_disable;
  logic [5:0] access_select;
  logic [3:0] int_status;
  logic [3:0] int_mask;
  pwj_pkg::pwj_pause_e pause_state;
  logic [1:0] pause_kind;
  logic [15:0] wd_cnt;
  logic wd_hold;
  logic rel_long;
  logic [5:0] hold_cnt;
  logic [15:0] jab_cnt;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wr_sel = reg_wr && reg_addr == pwj_pkg::ADDR_SELECT;
  wire wr_data = reg_wr && reg_addr == pwj_pkg::ADDR_DATA;
  wire rd_data = reg_rd && reg_addr == pwj_pkg::ADDR_DATA;
  wire wr_ctl = reg_wr && reg_addr == pwj_pkg::ADDR_CTRL;
  wire rd_ctl = reg_rd && reg_addr == pwj_pkg::ADDR_CTRL;
  wire wr_stat = reg_wr && reg_addr == pwj_pkg::ADDR_INT_STAT;
  wire wr_mask = reg_wr && reg_addr == pwj_pkg::ADDR_INT_MASK;
  wire [5:0] wsel = reg_wdata[pwj_pkg::SEL_MSB:pwj_pkg::SEL_LSB];

  // ----------------------------------------------------------------
  // Diagnostic FIFO routing
  // ----------------------------------------------------------------
  wire diag_clear = wr_sel && wsel == pwj_pkg::SEL_DIAG_RESET;
  wire [31:0] fifo_rdata [0:1];
  wire [pwj_pkg::DIAG_PTR_W-1:0] fifo_ptr [0:1];

  for (genvar i = 0; i < 2; i++) begin : g_fifo
    localparam logic [5:0] CODE =
      (i == 0) ? pwj_pkg::SEL_TX_FIFO : pwj_pkg::SEL_RX_FIFO;
    wire hit = access_select == CODE;
    pwj_diag_fifo u_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ptr_clear(diag_clear),
      .wr_en(wr_data && hit),
      .rd_en(rd_data && hit),
      .wr_data(reg_wdata),
      .rd_data(fifo_rdata[i]),
      .ptr(fifo_ptr[i])
    );
  end

  wire [31:0] data_read =
    (access_select == pwj_pkg::SEL_TX_FIFO) ? fifo_rdata[0] :
    (access_select == pwj_pkg::SEL_RX_FIFO) ? fifo_rdata[1] :
    32'h0000_0000;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] ctl_read = {16'h0000, pause_condition_mode, send_zero_pause,
    send_max_pause, pause_cond_b, pause_cond_a, flow_control_decode_enable,
    pause_received_latched, 1'b0, pause_decode_live, vlan_len_enable,
    watchdog_release_select, watchdog_timer_disable, 3'h0,
    tx_jabber_disable};
  wire [31:0] sel_read = {23'h000000, access_select, 3'h0};
  wire [31:0] rd_mux =
    (reg_addr == pwj_pkg::ADDR_SELECT) ? sel_read :
    (reg_addr == pwj_pkg::ADDR_DATA) ? data_read :
    (reg_addr == pwj_pkg::ADDR_CTRL) ? ctl_read :
    (reg_addr == pwj_pkg::ADDR_INT_STAT) ? {28'h0000000, int_status} :
    (reg_addr == pwj_pkg::ADDR_INT_MASK) ? {28'h0000000, int_mask} :
    32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Pause transmit request
  // ----------------------------------------------------------------
  wire p_idle = pause_state == pwj_pkg::PWJ_P_IDLE;
  wire p_busy = pause_state == pwj_pkg::PWJ_P_BUSY;
  wire cond_req = pause_condition_mode ? (pause_cond_a || pause_cond_b)
                                       : (pause_cond_a && pause_cond_b);
  wire start_zero = p_idle && send_zero_pause;
  wire start_max = p_idle && !send_zero_pause && send_max_pause;
  wire start_cond = p_idle && !send_zero_pause && !send_max_pause && cond_req;
  wire start_any = start_zero || start_max || start_cond;
  wire finish = p_busy && pause_tx_done;
  wire clr_zero = finish && pause_kind == pwj_pkg::KIND_ZERO;
  wire clr_max = finish && pause_kind == pwj_pkg::KIND_MAX;
  wire [1:0] next_kind = start_zero ? pwj_pkg::KIND_ZERO :
    start_max ? pwj_pkg::KIND_MAX : pwj_pkg::KIND_COND;
  wire [15:0] next_time = start_zero ? pwj_pkg::PAUSE_TIME_ZERO
                                     : pwj_pkg::PAUSE_TIME_MAX;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pause_state <= pwj_pkg::PWJ_P_IDLE;
      pause_kind <= pwj_pkg::KIND_COND;
      pause_tx_req <= 1'b0;
      pause_tx_time <= pwj_pkg::PAUSE_TIME_ZERO;
    end else begin
      case (pause_state)
        pwj_pkg::PWJ_P_IDLE: begin
          if (start_any) begin
            pause_state <= pwj_pkg::PWJ_P_BUSY;
            pause_kind <= next_kind;
            pause_tx_req <= 1'b1;
            pause_tx_time <= next_time;
          end
        end
        pwj_pkg::PWJ_P_BUSY: begin
          if (finish) begin
            pause_state <= pwj_pkg::PWJ_P_IDLE;
            pause_tx_req <= 1'b0;
          end
        end
        default: begin
          pause_state <= pwj_pkg::PWJ_P_IDLE;
          pause_tx_req <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  wire decoded = rx_pause_valid && flow_control_decode_enable;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pause_condition_mode <= pwj_pkg::RESET_CTRL_BIT;
      send_zero_pause <= pwj_pkg::RESET_CTRL_BIT;
      send_max_pause <= pwj_pkg::RESET_CTRL_BIT;
      flow_control_decode_enable <= pwj_pkg::RESET_CTRL_BIT;
      vlan_len_enable <= pwj_pkg::RESET_CTRL_BIT;
      watchdog_release_select <= pwj_pkg::RESET_CTRL_BIT;
      watchdog_timer_disable <= pwj_pkg::RESET_CTRL_BIT;
      tx_jabber_disable <= pwj_pkg::RESET_CTRL_BIT;
      pause_received_latched <= pwj_pkg::RESET_CTRL_BIT;
      pause_decode_live <= pwj_pkg::RESET_CTRL_BIT;
      access_select <= pwj_pkg::RESET_SEL;
    end else begin
      if (wr_ctl) begin
        pause_condition_mode <= reg_wdata[pwj_pkg::BIT_COND_MODE];
        flow_control_decode_enable <= reg_wdata[pwj_pkg::BIT_FLOW_EN];
        vlan_len_enable <= reg_wdata[pwj_pkg::BIT_VLAN];
        watchdog_release_select <= reg_wdata[pwj_pkg::BIT_REL_SEL];
        watchdog_timer_disable <= reg_wdata[pwj_pkg::BIT_WD_DIS];
        tx_jabber_disable <= reg_wdata[pwj_pkg::BIT_JAB_DIS];
      end
      send_zero_pause <= wr_ctl ? reg_wdata[pwj_pkg::BIT_SEND_ZERO]
                                : send_zero_pause && !clr_zero;
      send_max_pause <= wr_ctl ? reg_wdata[pwj_pkg::BIT_SEND_MAX]
                               : send_max_pause && !clr_max;
      pause_received_latched <= decoded ||
                                (pause_received_latched && !rd_ctl);
      pause_decode_live <= decoded;
      if (wr_sel) begin
        access_select <= wsel;
      end
    end
  end

  // ----------------------------------------------------------------
  // Received pause and frame length
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_pause_apply <= 1'b0;
      rx_pause_quanta <= pwj_pkg::PAUSE_TIME_ZERO;
      max_frame_len <= pwj_pkg::LEN_STD;
    end else begin
      rx_pause_apply <= decoded;
      if (decoded) begin
        rx_pause_quanta <= rx_pause_time;
      end
      max_frame_len <= vlan_len_enable ? pwj_pkg::LEN_VLAN
                                       : pwj_pkg::LEN_STD;
    end
  end

  // ----------------------------------------------------------------
  // Receive watchdog
  // ----------------------------------------------------------------
  wire wd_run = rx_active && !watchdog_timer_disable && !wd_hold;
  wire wd_expire = wd_run && wd_cnt == 16'(WD_EXPIRE_CYCLES - 1);
  wire [5:0] rel_len = rel_long ? 6'(pwj_pkg::REL_LONG_CYC)
                                : 6'(pwj_pkg::REL_SHORT_CYC);
  wire hold_done = wd_hold && hold_cnt == 6'(rel_len - 6'h01);
  wire next_wd_hold = wd_expire || (wd_hold && !hold_done);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wd_cnt <= 16'h0000;
      wd_hold <= 1'b0;
      rel_long <= 1'b0;
      hold_cnt <= 6'h00;
      rx_channel_enable <= 1'b1;
    end else begin
      wd_cnt <= (wd_run && !wd_expire) ? wd_cnt + 16'h0001 : 16'h0000;
      wd_hold <= next_wd_hold;
      hold_cnt <= wd_hold ? hold_cnt + 6'h01 : 6'h00;
      if (wd_expire) begin
        rel_long <= watchdog_release_select;
      end
      rx_channel_enable <= !next_wd_hold;
    end
  end

  // ----------------------------------------------------------------
  // Transmit jabber
  // ----------------------------------------------------------------
  wire jab_run = tx_active && !tx_jabber_disable && !tx_jabber_cut;
  wire jab_hit = jab_run && jab_cnt == 16'(JAB_EXPIRE_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      jab_cnt <= 16'h0000;
      tx_jabber_cut <= 1'b0;
    end else begin
      jab_cnt <= (jab_run && !jab_hit) ? jab_cnt + 16'h0001 : 16'h0000;
      tx_jabber_cut <= !tx_jabber_disable && tx_active &&
                       (tx_jabber_cut || jab_hit);
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire [3:0] events = {jab_hit, wd_expire, finish, decoded};
  wire [3:0] stat_clr = wr_stat ? reg_wdata[3:0] : 4'h0;
  wire [3:0] next_status = events | (int_status & ~stat_clr);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_status <= pwj_pkg::RESET_INT;
      int_mask <= pwj_pkg::RESET_INT;
      irq <= 1'b0;
    end else begin
      int_status <= next_status;
      if (wr_mask) begin
        int_mask <= reg_wdata[3:0];
      end
      irq <= |(int_status & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [6:0] low_len;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      low_len <= 7'h00;
    end else begin
      low_len <= rx_channel_enable ? 7'h00 : low_len + 7'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_either_cond: assert property (
    p_idle && pause_condition_mode && (pause_cond_a ^ pause_cond_b) &&
    !send_zero_pause && !send_max_pause
    |=> pause_tx_req && pause_tx_time == 16'hffff)
    else $error("pause not requested on single condition");
  a_both_cond: assert property (
    p_idle && !pause_condition_mode && !(pause_cond_a && pause_cond_b) &&
    !send_zero_pause && !send_max_pause |=> !pause_tx_req)
    else $error("pause requested without both conditions");
  a_zero_send: assert property (
    p_idle && send_zero_pause |=> pause_tx_req && pause_tx_time == 16'h0000)
    else $error("zero pause not sent");
  a_zero_clear: assert property (
    clr_zero && !wr_ctl |=> !send_zero_pause && !pause_tx_req)
    else $error("zero pause command not cleared");
  a_max_send: assert property (
    start_max |=> pause_tx_req && pause_tx_time == 16'hffff)
    else $error("max pause not sent");
  a_decode_gate: assert property (
    rx_pause_valid |=> rx_pause_apply == $past(flow_control_decode_enable))
    else $error("pause decode ignores enable");
  a_latch_hold: assert property (
    decoded |=> pause_received_latched until_with rd_ctl)
    else $error("pause latch lost before read");
  a_live_bit: assert property (
    ##1 ctl_read[7] == $past(decoded))
    else $error("live pause bit wrong");
  a_vlan_len: assert property (
    $stable(vlan_len_enable) |-> max_frame_len ==
      (vlan_len_enable ? 11'h5f2 : 11'h5ee))
    else $error("frame length wrong");
  a_release_len: assert property (
    $rose(rx_channel_enable) |-> low_len == {1'b0, rel_len})
    else $error("release interval wrong");
  a_wd_block: assert property (
    wd_expire |=> !rx_channel_enable [*8])
    else $error("receive not disabled on expiry");
  a_wd_stop: assert property (
    watchdog_timer_disable |=> wd_cnt == 16'h0000)
    else $error("watchdog ran while disabled");
  a_jab_off: assert property (
    tx_jabber_disable |=> !tx_jabber_cut)
    else $error("jabber cut while disabled");
  a_diag_reset: assert property (
    diag_clear |=> fifo_ptr[0] == 4'h0 && fifo_ptr[1] == 4'h0)
    else $error("diagnostic pointers not reset");

endmodule : pwj_ctrl
`default_nettype wire

// *** bench/pwj_link_peer.sv ***
// Link partner model: completes pause frames and sends received pauses
`timescale 1ns/1ns
`default_nettype none
module pwj_link_peer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic pause_tx_req,
  input wire logic [15:0] pause_tx_time,
  input wire logic [7:0] done_lat,
  output logic pause_tx_done,
  output logic rx_pause_valid,
  output logic [15:0] rx_pause_time,
  output logic [15:0] sent_time,
  output logic [7:0] sent_cnt
);
  logic [7:0] wait_cnt;
  initial begin
    rx_pause_valid = 1'b0;
    rx_pause_time = 16'h5a5a;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pause_tx_done <= 1'b0;
      wait_cnt <= 8'h00;
      sent_time <= 16'h5a5a;
      sent_cnt <= 8'h00;
    end else begin
      pause_tx_done <= 1'b0;
      if (pause_tx_req && !pause_tx_done) begin
        wait_cnt <= wait_cnt + 8'h01;
        if (wait_cnt >= done_lat) begin
          pause_tx_done <= 1'b1;
          sent_time <= pause_tx_time;
          sent_cnt <= sent_cnt + 8'h01;
          wait_cnt <= 8'h00;
        end
      end
    end
  end
  // Time lines flip after a frame so a stale value never matches
  task automatic send_pause(input logic [15:0] t);
    @(posedge sys_clk);
    rx_pause_valid <= 1'b1;
    rx_pause_time <= t;
    @(posedge sys_clk);
    rx_pause_valid <= 1'b0;
    rx_pause_time <= ~t;
  endtask : send_pause
endmodule : pwj_link_peer
`default_nettype wire

// *** bench/pwj_ctrl_tb.sv ***
// Self-checking testbench for the pause, watchdog and jabber control block
`timescale 1ns/1ns
`default_nettype none
module pwj_ctrl_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic cond_a = 1'b0;
  logic cond_b = 1'b0;
  logic rx_active = 1'b0;
  logic tx_active = 1'b0;
  logic [7:0] lat = 8'h00;
  logic req, done, rxv, apply, rx_en, cut, irq;
  logic [15:0] req_time, rx_time, quanta, sent_time;
  logic [10:0] len;
  logic [7:0] sent_cnt;
  int n_mismatch = 0;
  int checked = 0;
  int n_apply = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (apply === 1'b1) n_apply++;
  pwj_ctrl #(.WD_EXPIRE_CYCLES(20), .JAB_EXPIRE_CYCLES(20)) i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pause_cond_a(cond_a), .pause_cond_b(cond_b),
    .pause_tx_req(req), .pause_tx_time(req_time), .pause_tx_done(done),
    .rx_pause_valid(rxv), .rx_pause_time(rx_time), .rx_pause_apply(apply),
    .rx_pause_quanta(quanta), .max_frame_len(len), .rx_active(rx_active),
    .rx_channel_enable(rx_en), .tx_active(tx_active),
    .tx_jabber_cut(cut), .irq(irq));
  pwj_link_peer i_peer (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .pause_tx_req(req), .pause_tx_time(req_time), .done_lat(lat),
    .pause_tx_done(done), .rx_pause_valid(rxv), .rx_pause_time(rx_time),
    .sent_time(sent_time), .sent_cnt(sent_cnt));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic chk1(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask : chk1
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask : rdc
  function automatic logic [31:0] sel(input logic [5:0] c);
    return {23'h0, c, 3'h0};
  endfunction : sel
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial begin
    #3000000;
    n_mismatch++;
    close_out();
  end
  initial begin
    int n;
    logic e;
    logic [15:0] t;
    logic [31:0] fw [2][4];
    void'($urandom(32'h6eca));
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdc("ctrl", pwj_pkg::ADDR_CTRL, 32'h0);
    rdc("unmapped", 8'h20, 32'h0);
    chk1("rx_en", 1'b1, rx_en);
    wr(pwj_pkg::ADDR_CTRL, 32'h40);
    cyc(2);
    chk("len", 32'h5f2, {21'h0, len});
    wr(pwj_pkg::ADDR_CTRL, 32'h0);
    cyc(2);
    chk("len", 32'h5ee, {21'h0, len});
    for (int k = 0; k < 2; k++) begin
      lat <= 8'($urandom_range(15, 0));
      n = sent_cnt;
      wr(pwj_pkg::ADDR_CTRL, k ? 32'h2000 : 32'h4000);
      for (int w = 0; w < 100 && sent_cnt == 8'(n); w++) cyc(1);
      cyc(2);
      chk("time", k ? 32'hffff : 32'h0, {16'h0, sent_time});
      rdc("ctrl", pwj_pkg::ADDR_CTRL, 32'h0);
      chk1("irq", 1'b0, irq);
    end
    rdc("status", pwj_pkg::ADDR_INT_STAT, 32'h2);
    wr(pwj_pkg::ADDR_INT_MASK, 32'h2);
    cyc(2);
    chk1("irq", 1'b1, irq);
    wr(pwj_pkg::ADDR_INT_STAT, 32'h2);
    cyc(2);
    chk1("irq", 1'b0, irq);
    lat <= 8'h1e;
    for (int i = 0; i < 8; i++) begin
      wr(pwj_pkg::ADDR_CTRL, {16'h0, i[2], 15'h1a80});
      cond_a <= i[0];
      cond_b <= i[1];
      e = i[2] ? (i[0] | i[1]) : (i[0] & i[1]);
      cyc(3);
      chk1("req", e, req);
      rdc("ctrl", pwj_pkg::ADDR_CTRL, {16'h0, i[2], 2'h0, i[1], i[0], 11'h0});
      cond_a <= 1'b0;
      cond_b <= 1'b0;
      for (int w = 0; w < 100 && req !== 1'b0; w++) cyc(1);
      if (e) chk("ctime", 32'hffff, {16'h0, sent_time});
    end
    for (int k = 0; k < 2; k++) begin
      wr(pwj_pkg::ADDR_CTRL, k ? 32'h400 : 32'h0);
      n = n_apply;
      t = 16'($urandom);
      i_peer.send_pause(t);
      cyc(3);
      chk("apply", n + k, n_apply);
      if (k) chk("quanta", {16'h0, t}, {16'h0, quanta});
      rdc("latched", pwj_pkg::ADDR_CTRL, k ? 32'h600 : 32'h0);
      rdc("cleared", pwj_pkg::ADDR_CTRL, k ? 32'h400 : 32'h0);
    end
    rdc("status", pwj_pkg::ADDR_INT_STAT, 32'h3);
    for (int k = 0; k < 3; k++) begin
      wr(pwj_pkg::ADDR_CTRL, k == 2 ? 32'h10 : {26'h0, k[0], 5'h0});
      rx_active <= 1'b1;
      for (n = 0; n < 60 && rx_en !== 1'b0; n++) cyc(1);
      rx_active <= 1'b0;
      for (n = 0; n < 100 && rx_en === 1'b0; n++) cyc(1);
      chk("release", k == 2 ? 0 : k ? 40 : 16, n);
    end
    for (int k = 0; k < 2; k++) begin
      wr(pwj_pkg::ADDR_CTRL, {31'h0, k[0]});
      tx_active <= 1'b1;
      cyc(30);
      chk1("cut", !k[0], cut);
      tx_active <= 1'b0;
      cyc(2);
      chk1("cut", 1'b0, cut);
    end
    for (int k = 0; k < 2; k++) begin
      wr(pwj_pkg::ADDR_SELECT, sel(6'h38));
      wr(pwj_pkg::ADDR_SELECT, sel(k ? 6'h35 : 6'h32));
      rdc("sel", pwj_pkg::ADDR_SELECT, sel(k ? 6'h35 : 6'h32));
      for (int j = 0; j < 4; j++) begin
        fw[k][j] = $urandom;
        wr(pwj_pkg::ADDR_DATA, fw[k][j]);
      end
    end
    for (int k = 0; k < 2; k++) begin
      wr(pwj_pkg::ADDR_SELECT, sel(6'h38));
      wr(pwj_pkg::ADDR_SELECT, sel(k ? 6'h35 : 6'h32));
      for (int j = 0; j < 4; j++)
        rdc("fifo", pwj_pkg::ADDR_DATA, fw[k][j]);
    end
    wr(pwj_pkg::ADDR_SELECT, sel(6'h38));
    rdc("diag", pwj_pkg::ADDR_DATA, 32'h0);
    close_out();
  end
endmodule : pwj_ctrl_tb
`default_nettype wire
